// ===== hdl/shss_halt_selector.sv
`timescale 1ns/1ns
// Summary of operation
// - the halt option picks how the motor is brought to rest and its meaning depends on the mode.
// - any option value is stored, but only values one to three select a stop method (one and two in the torque modes); any other selects none.
// - in the position and velocity modes option 1 stops on the profile deceleration rate.
// - in those modes option 2 uses quick-stop deceleration and 3 uses max torque with max decel.
// - in homing mode options 1, 2 and 3 use homing accel, quick-stop and max torque/max decel.
// - in the torque modes options 1 and 2 ramp torque down at the torque slope rate.
// - a 0 to 1 change of control word bit 8 starts the halt deceleration.
// - during a halt deceleration the power drive state machine stays in its operating state.
// - the motor is declared stopped at or below 30 r/min and the operating state is kept after.
module shss_halt_selector
    import shss_pkg::*;
(
    input wire logic clk, // 100 MHz control clock
    input wire logic nrst, // async reset, active low
    input wire logic obj_wr, // object write strobe
    input wire logic [15:0] obj_index, // object index
    input wire logic [31:0] obj_wdata, // object write data
    input wire logic obj_rd, // object read strobe
    output logic [31:0] obj_rdata_q, // read data, one cycle after obj_rd
    output logic obj_rvalid_q, // read data valid pulse
    output logic obj_err_q, // unmapped index pulse
    input wire logic [7:0] op_mode, // active operation mode, same clock
    input wire logic signed [31:0] actual_vel_rpm, // measured velocity, same clock
    output logic halt_active_q, // halt deceleration under way
    output logic motor_stopped_q, // velocity reached stop threshold during halt
    output logic [2:0] ramp_sel_q, // selected ramp source
    output logic [31:0] ramp_rate_q, // latched ramp value
    output logic [31:0] ramp_limit_q, // latched max deceleration for max-torque stop
    output logic pds_op_enabled_q // power drive state machine held in operation enabled
);
    logic [31:0] profile_decel_rate_q;
    logic [31:0] quick_decel_rate_q;
    logic [31:0] torque_ramp_rate_q;
    logic [31:0] homing_accel_rate_q;
    logic [31:0] max_torque_q;
    logic [31:0] max_decel_q;
    logic [15:0] halt_stop_option_q;
    logic [15:0] control_word_q;
    logic halt_prev_q;
    shss_state_t state_q;
    shss_ramp_t ramp_d;
    logic [31:0] rate_d;
    logic [31:0] vel_abs;
    logic halt_rise;
    logic posvel_mode;
    logic torque_mode;

    // status is read-only; a write there is dropped without an error
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            profile_decel_rate_q <= SHSS_RATE_RESET;
            quick_decel_rate_q <= SHSS_RATE_RESET;
            torque_ramp_rate_q <= SHSS_RATE_RESET;
            homing_accel_rate_q <= SHSS_RATE_RESET;
            max_torque_q <= SHSS_RATE_RESET;
            max_decel_q <= SHSS_RATE_RESET;
            halt_stop_option_q <= SHSS_HALT_OPT_RESET;
            control_word_q <= 16'h0000;
        end else if (obj_wr) begin
            if (obj_index == SHSS_IDX_PROFILE_DECEL) begin
                profile_decel_rate_q <= obj_wdata;
            end else if (obj_index == SHSS_IDX_QUICK_DECEL) begin
                quick_decel_rate_q <= obj_wdata;
            end else if (obj_index == SHSS_IDX_TORQUE_RAMP) begin
                torque_ramp_rate_q <= obj_wdata;
            end else if (obj_index == SHSS_IDX_HOMING_ACCEL) begin
                homing_accel_rate_q <= obj_wdata;
            end else if (obj_index == SHSS_IDX_MAX_TORQUE) begin
                max_torque_q <= obj_wdata;
            end else if (obj_index == SHSS_IDX_MAX_DECEL) begin
                max_decel_q <= obj_wdata;
            end else if (obj_index == SHSS_IDX_HALT_OPTION) begin
                halt_stop_option_q <= obj_wdata[15:0];
            end else if (obj_index == SHSS_IDX_CONTROL_WORD) begin
                control_word_q <= obj_wdata[15:0];
            end
        end
    end

    // reads answer one cycle later; unknown index flags an error on either access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            obj_rdata_q <= 32'h0000_0000;
            obj_rvalid_q <= 1'b0;
            obj_err_q <= 1'b0;
        end else begin
            obj_rvalid_q <= obj_rd;
            obj_err_q <= 1'b0;
            obj_rdata_q <= 32'h0000_0000;
            if (obj_rd || obj_wr) begin
                if (obj_index == SHSS_IDX_PROFILE_DECEL) begin
                    obj_rdata_q <= profile_decel_rate_q;
                end else if (obj_index == SHSS_IDX_QUICK_DECEL) begin
                    obj_rdata_q <= quick_decel_rate_q;
                end else if (obj_index == SHSS_IDX_TORQUE_RAMP) begin
                    obj_rdata_q <= torque_ramp_rate_q;
                end else if (obj_index == SHSS_IDX_HOMING_ACCEL) begin
                    obj_rdata_q <= homing_accel_rate_q;
                end else if (obj_index == SHSS_IDX_MAX_TORQUE) begin
                    obj_rdata_q <= max_torque_q;
                end else if (obj_index == SHSS_IDX_MAX_DECEL) begin
                    obj_rdata_q <= max_decel_q;
                end else if (obj_index == SHSS_IDX_HALT_OPTION) begin
                    obj_rdata_q <= {16'h0000, halt_stop_option_q};
                end else if (obj_index == SHSS_IDX_CONTROL_WORD) begin
                    obj_rdata_q <= {16'h0000, control_word_q};
                end else if (obj_index == SHSS_IDX_STATUS) begin
                    obj_rdata_q <= {26'h0000000, ramp_sel_q, motor_stopped_q,
                                    halt_active_q, pds_op_enabled_q};
                end else begin
                    obj_err_q <= 1'b1;
                end
            end
        end
    end

    // csp, ip and csv share the option meanings of the profile position and velocity modes
    assign posvel_mode = (op_mode == SHSS_MODE_PP) || (op_mode == SHSS_MODE_CSP) ||
                         (op_mode == SHSS_MODE_IP) || (op_mode == SHSS_MODE_CSV) ||
                         (op_mode == SHSS_MODE_PV);
    assign torque_mode = (op_mode == SHSS_MODE_CST) || (op_mode == SHSS_MODE_TQ);

    // mode-dependent ramp choice from the live option and mode
    always_comb begin
        ramp_d = SHSS_RAMP_NONE;
        rate_d = 32'h0000_0000;
        if (posvel_mode) begin
            if (halt_stop_option_q == 16'h0001) begin
                ramp_d = SHSS_RAMP_PROFILE;
                rate_d = profile_decel_rate_q;
            end else if (halt_stop_option_q == 16'h0002) begin
                ramp_d = SHSS_RAMP_QUICK;
                rate_d = quick_decel_rate_q;
            end else if (halt_stop_option_q == 16'h0003) begin
                ramp_d = SHSS_RAMP_MAXTQ;
                rate_d = max_torque_q;
            end
        end else if (op_mode == SHSS_MODE_HM) begin
            if (halt_stop_option_q == 16'h0001) begin
                ramp_d = SHSS_RAMP_HOMING;
                rate_d = homing_accel_rate_q;
            end else if (halt_stop_option_q == 16'h0002) begin
                ramp_d = SHSS_RAMP_QUICK;
                rate_d = quick_decel_rate_q;
            end else if (halt_stop_option_q == 16'h0003) begin
                ramp_d = SHSS_RAMP_MAXTQ;
                rate_d = max_torque_q;
            end
        end else if (torque_mode) begin
            if (halt_stop_option_q == 16'h0001 || halt_stop_option_q == 16'h0002) begin
                ramp_d = SHSS_RAMP_TORQUE;
                rate_d = torque_ramp_rate_q;
            end
        end
    end

    assign halt_rise = control_word_q[SHSS_HALT_BIT] && !halt_prev_q;
    // most negative velocity wraps to itself, still far above the threshold
    assign vel_abs = actual_vel_rpm[31] ? 32'(-actual_vel_rpm) : 32'(actual_vel_rpm);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            halt_prev_q <= 1'b0;
        end else begin
            halt_prev_q <= control_word_q[SHSS_HALT_BIT];
        end
    end

    // a disabled option leaves the halt unanswered and nothing latched
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SHSS_ST_RUN;
            ramp_sel_q <= SHSS_RAMP_NONE;
            ramp_rate_q <= 32'h0000_0000;
            ramp_limit_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                SHSS_ST_RUN: begin
                    if (halt_rise && ramp_d != SHSS_RAMP_NONE) begin
                        state_q <= SHSS_ST_DECEL;
                        ramp_sel_q <= ramp_d;
                        ramp_rate_q <= rate_d;
                        ramp_limit_q <= (ramp_d == SHSS_RAMP_MAXTQ) ? max_decel_q
                                                                    : 32'h0000_0000;
                    end
                end
                SHSS_ST_DECEL: begin
                    // host dropping the halt bit abandons the stop at once
                    if (!control_word_q[SHSS_HALT_BIT]) begin
                        state_q <= SHSS_ST_RUN;
                        ramp_sel_q <= SHSS_RAMP_NONE;
                    end else if (vel_abs <= SHSS_STOP_VEL_RPM) begin
                        state_q <= SHSS_ST_HELD;
                    end
                end
                SHSS_ST_HELD: begin
                    if (!control_word_q[SHSS_HALT_BIT]) begin
                        state_q <= SHSS_ST_RUN;
                        ramp_sel_q <= SHSS_RAMP_NONE;
                    end
                end
                default: begin
                    state_q <= SHSS_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            halt_active_q <= 1'b0;
            motor_stopped_q <= 1'b0;
            pds_op_enabled_q <= 1'b1;
        end else begin
            halt_active_q <= (state_q == SHSS_ST_DECEL);
            motor_stopped_q <= (state_q == SHSS_ST_HELD);
            pds_op_enabled_q <= 1'b1;
        end
    end
endmodule // shss_halt_selector

// ===== hdl/shss_pkg.sv
package shss_pkg;
    // object-dictionary indices of the registers reached over the object port
    localparam logic [15:0] SHSS_IDX_PROFILE_DECEL = 16'h6084;
    localparam logic [15:0] SHSS_IDX_QUICK_DECEL = 16'h6085;
    localparam logic [15:0] SHSS_IDX_TORQUE_RAMP = 16'h6087;
    localparam logic [15:0] SHSS_IDX_HOMING_ACCEL = 16'h609A;
    localparam logic [15:0] SHSS_IDX_MAX_TORQUE = 16'h6072;
    localparam logic [15:0] SHSS_IDX_MAX_DECEL = 16'h60C6;
    localparam logic [15:0] SHSS_IDX_HALT_OPTION = 16'h605D;
    localparam logic [15:0] SHSS_IDX_CONTROL_WORD = 16'h6040;
    localparam logic [15:0] SHSS_IDX_STATUS = 16'h3F00;
    localparam int SHSS_HALT_BIT = 8;
    localparam logic [15:0] SHSS_HALT_OPT_RESET = 16'h0001;
    localparam logic [31:0] SHSS_RATE_RESET = 32'h0000_0000;
    // stop threshold in r/min; velocity input is signed r/min
    localparam logic [31:0] SHSS_STOP_VEL_RPM = 32'h0000_001E;
    // operation mode codes as carried on the mode input
    localparam logic [7:0] SHSS_MODE_PP = 8'h01;
    localparam logic [7:0] SHSS_MODE_PV = 8'h03;
    localparam logic [7:0] SHSS_MODE_TQ = 8'h04;
    localparam logic [7:0] SHSS_MODE_HM = 8'h06;
    localparam logic [7:0] SHSS_MODE_IP = 8'h07;
    localparam logic [7:0] SHSS_MODE_CSP = 8'h08;
    localparam logic [7:0] SHSS_MODE_CSV = 8'h09;
    localparam logic [7:0] SHSS_MODE_CST = 8'h0A;

    typedef enum logic [2:0] {
        SHSS_RAMP_NONE = 3'h0,
        SHSS_RAMP_PROFILE = 3'h1,
        SHSS_RAMP_QUICK = 3'h2,
        SHSS_RAMP_MAXTQ = 3'h3,
        SHSS_RAMP_HOMING = 3'h4,
        SHSS_RAMP_TORQUE = 3'h5
    } shss_ramp_t;

    typedef enum logic [2:0] {
        SHSS_ST_RUN = 3'b001,
        SHSS_ST_DECEL = 3'b010,
        SHSS_ST_HELD = 3'b100
    } shss_state_t;
endpackage

// ===== tb/shss_halt_props.sv
`timescale 1ns/1ns
module shss_halt_props
    import shss_pkg::*;
(
    input wire logic clk, // clock
    input wire logic nrst, // reset, active low
    input wire logic obj_wr, // write strobe
    input wire logic [15:0] obj_index, // object index
    input wire logic [7:0] op_mode, // operation mode
    input wire logic signed [31:0] actual_vel_rpm, // velocity
    input wire logic halt_active_q, // halting
    input wire logic motor_stopped_q, // stopped
    input wire logic [2:0] ramp_sel_q, // ramp source
    input wire logic [31:0] ramp_rate_q, // ramp value
    input wire logic pds_op_enabled_q // operating state kept
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic slow;
    assign slow = actual_vel_rpm <= 30 && actual_vel_rpm >= -30;
    a_halt_from_write: assert property ($rose(halt_active_q) |->
        $past(obj_wr, 3) && $past(obj_index, 3) == SHSS_IDX_CONTROL_WORD) else $error("bad start");
    a_halt_needs_ramp: assert property ($rose(halt_active_q) |->
        ramp_sel_q != SHSS_RAMP_NONE) else $error("halt with no ramp");
    a_torque_mode_ramp: assert property ($rose(halt_active_q) &&
        (op_mode == SHSS_MODE_TQ || op_mode == SHSS_MODE_CST) |->
        ramp_sel_q == SHSS_RAMP_TORQUE) else $error("torque ramp wrong");
    a_ramp_held: assert property (halt_active_q && $past(halt_active_q) |->
        $stable(ramp_rate_q) && ($stable(ramp_sel_q) || ramp_sel_q == SHSS_RAMP_NONE))
        else $error("ramp changed");
    a_pds_kept: assert property (pds_op_enabled_q) else $error("left operation");
    a_stop_declared: assert property (halt_active_q && slow |=> ##1
        (motor_stopped_q || $past(obj_wr) || $past(obj_wr, 2) || $past(obj_wr, 3) ||
        $past(obj_wr, 4))) else $error("no stop");
    a_stop_slow_only: assert property ($rose(motor_stopped_q) |->
        $past(slow, 2)) else $error("stop too fast");
    a_stop_ends_decel: assert property (motor_stopped_q |->
        !halt_active_q) else $error("still halting");
    c_stop: cover property ($rose(motor_stopped_q));
    c_maxtq: cover property ($rose(halt_active_q) && ramp_sel_q == SHSS_RAMP_MAXTQ);
    c_homing: cover property ($rose(halt_active_q) && ramp_sel_q == SHSS_RAMP_HOMING);
endmodule // shss_halt_props
bind shss_halt_selector shss_halt_props u_props (.clk(clk), .nrst(nrst), .obj_wr(obj_wr),
    .obj_index(obj_index), .op_mode(op_mode), .actual_vel_rpm(actual_vel_rpm),
    .halt_active_q(halt_active_q), .motor_stopped_q(motor_stopped_q),
    .ramp_sel_q(ramp_sel_q), .ramp_rate_q(ramp_rate_q), .pds_op_enabled_q(pds_op_enabled_q));

// ===== tb/shss_master_model.sv
`timescale 1ns/1ns
module shss_master_model
    import shss_pkg::*;
(
    input wire logic clk, // clock
    output logic obj_wr = 1'b0, // write strobe
    output logic obj_rd = 1'b0, // read strobe
    output logic [15:0] obj_index = 16'h0000, // object index
    output logic [31:0] obj_wdata = 32'h0000_0000, // write data
    input wire logic [31:0] obj_rdata_q, // read data
    input wire logic obj_rvalid_q, // read valid
    input wire logic obj_err_q // unmapped index
);
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(negedge clk);
        obj_index = idx;
        obj_wdata = d;
        obj_wr = 1'b1;
        @(negedge clk);
        obj_wr = 1'b0;
        // released lines must not keep looking valid
        obj_index = ~obj_index;
        obj_wdata = ~obj_wdata;
    endtask
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] f);
        @(negedge clk);
        obj_index = idx;
        obj_rd = 1'b1;
        @(negedge clk);
        d = obj_rdata_q;
        f = {obj_err_q, obj_rvalid_q};
        obj_rd = 1'b0;
        obj_index = ~obj_index;
    endtask
    task automatic halt(input logic b);
        wr(SHSS_IDX_CONTROL_WORD, {23'h0, b, 8'h00});
    endtask
endmodule // shss_master_model

// ===== tb/shss_halt_selector_tb_top.sv
`timescale 1ns/1ns
module shss_halt_selector_tb_top import shss_pkg::*; ;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] op_mode = SHSS_MODE_PP;
    logic signed [31:0] vel = 32'sh0000_01F4;
    logic obj_wr, obj_rd, obj_rvalid_q, obj_err_q, halt_active_q, motor_stopped_q, pds_q;
    logic [15:0] obj_index;
    logic [31:0] obj_wdata, obj_rdata_q, ramp_rate_q, ramp_limit_q;
    logic [2:0] ramp_sel_q;
    int err_total = 0;
    int n_compared = 0;
    logic [31:0] last_rate = 32'h0000_0000;
    logic [31:0] last_lim = 32'h0000_0000;
    logic [31:0] rate [6] = '{32'h0, 32'h11, 32'h22, 32'h55, 32'h44, 32'h33};
    logic [15:0] idx_of [6] = '{SHSS_IDX_PROFILE_DECEL, SHSS_IDX_PROFILE_DECEL,
        SHSS_IDX_QUICK_DECEL, SHSS_IDX_MAX_TORQUE, SHSS_IDX_HOMING_ACCEL, SHSS_IDX_TORQUE_RAMP};
    // {mode, option, expected ramp source}
    logic [23:0] cases [12] = '{24'h010101, 24'h080202, 24'h070303, 24'h090101, 24'h030202,
        24'h060104, 24'h060202, 24'h060303, 24'h040105, 24'h0A0205, 24'h010000, 24'h060400};
    always #5 clk = ~clk;
    shss_halt_selector DUT (.clk(clk), .nrst(nrst), .obj_wr(obj_wr), .obj_index(obj_index),
        .obj_wdata(obj_wdata), .obj_rd(obj_rd), .obj_rdata_q(obj_rdata_q),
        .obj_rvalid_q(obj_rvalid_q), .obj_err_q(obj_err_q), .op_mode(op_mode),
        .actual_vel_rpm(vel), .halt_active_q(halt_active_q), .motor_stopped_q(motor_stopped_q),
        .ramp_sel_q(ramp_sel_q), .ramp_rate_q(ramp_rate_q), .ramp_limit_q(ramp_limit_q),
        .pds_op_enabled_q(pds_q));
    shss_master_model u_host (.clk(clk), .obj_wr(obj_wr), .obj_rd(obj_rd),
        .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata_q(obj_rdata_q),
        .obj_rvalid_q(obj_rvalid_q), .obj_err_q(obj_err_q));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] fe);
        logic [31:0] d;
        logic [1:0] f;
        u_host.rd(idx, d, f);
        chk("read data", d, exp);
        chk("read flags", 32'(f), 32'(fe));
    endtask
    task automatic t_regs;
        rchk(SHSS_IDX_HALT_OPTION, 32'h1, 2'b01);
        rchk(SHSS_IDX_PROFILE_DECEL, 32'h0, 2'b01);
        for (int i = 1; i < 6; i++) u_host.wr(idx_of[i], rate[i]);
        u_host.wr(SHSS_IDX_MAX_DECEL, 32'h66);
        for (int i = 1; i < 6; i++) rchk(idx_of[i], rate[i], 2'b01);
        rchk(SHSS_IDX_STATUS, 32'h1, 2'b01);
        rchk(16'h1234, 32'h0, 2'b11);
        $display("test registers done");
    endtask
    task automatic t_halt(input logic [7:0] m, input logic [15:0] o, input logic [2:0] s);
        logic [31:0] r;
        if (s != 3'h0) begin
            last_rate = rate[s];
            last_lim = (s == 3'h3) ? 32'h66 : 32'h0;
        end
        r = last_rate;
        u_host.wr(SHSS_IDX_HALT_OPTION, {16'h0, o});
        op_mode = m;
        vel = 32'sh0000_01F4;
        u_host.halt(1'b1);
        repeat (2) @(negedge clk);
        chk("halt active", 32'(halt_active_q), 32'(s != 3'h0));
        chk("ramp source", 32'(ramp_sel_q), 32'(s));
        chk("ramp rate", ramp_rate_q, r);
        chk("ramp limit", ramp_limit_q, last_lim);
        chk("pds", 32'(pds_q), 32'h1);
        vel = 32'sh0000_001F;
        if (s != 3'h0) begin
            u_host.wr(idx_of[s], 32'hFF);
            u_host.wr(SHSS_IDX_HALT_OPTION, 32'h2);
            chk("rate kept", ramp_rate_q, r);
            chk("source kept", 32'(ramp_sel_q), 32'(s));
            u_host.wr(idx_of[s], r);
        end
        chk("not stopped", 32'(motor_stopped_q), 32'h0);
        vel = -32'sh0000_001E;
        repeat (3) @(negedge clk);
        chk("stopped", 32'(motor_stopped_q), 32'(s != 3'h0));
        chk("pds after", 32'(pds_q), 32'h1);
        rchk(SHSS_IDX_STATUS, {26'h0000000, s, (s != 3'h0), 2'b01}, 2'b01);
        u_host.halt(1'b0);
        repeat (2) @(negedge clk);
        chk("released", 32'(motor_stopped_q), 32'h0);
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        stop_test;
    end
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        t_regs;
        foreach (cases[i]) t_halt(cases[i][23:16], {8'h00, cases[i][15:8]}, cases[i][2:0]);
        $display("test halt table done");
        stop_test;
    end
endmodule // shss_halt_selector_tb_top
